// >>> src/gps_consts.vh
// gps_consts.vh: constants for the gpib port configuration and service request block
// assumes a 50 MHz core clock; included by the port configuration module by bare name
`ifndef GPS_CONSTS_VH
`define GPS_CONSTS_VH

// ------------------------------------------------------------
// status byte layout
// ------------------------------------------------------------
`define GPS_RQS_BIT       6
`define GPS_MASK_ALL_ON   8'hff
`define GPS_MASK_ALL_OFF  8'h00

// ------------------------------------------------------------
// characters
// ------------------------------------------------------------
`define GPS_CHAR_LF       8'h0a
`define GPS_CHAR_CR       8'h0d

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define GPS_CLK_HZ        50000000
`define GPS_IFC_TIME_US   100
// rate scaled down first: pulse time times the raw rate overflows 32 bits
`define GPS_IFC_CYCLES    (`GPS_IFC_TIME_US * (`GPS_CLK_HZ / 1000000))
`define GPS_STRAP_TAKE    2'h2
`define GPS_TMO_SECS_W    8

`endif

// >>> src/gps_sync2.v
// gps_sync2.v: two flip-flop synchroniser for pin inputs
// assumes the input is asynchronous to i_clk
`timescale 1ns/1ps
`default_nettype none

module gps_sync2 #(
	parameter W = 1
) (
	// clock and control
	input  wire         i_clk,
	input  wire         i_rst_n,
	input  wire         i_ce,
	// data
	input  wire [W-1:0] i_async,
	output reg  [W-1:0] o_sync
);

	reg [W-1:0] meta_reg;

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_reg <= {W{1'b0}};
			o_sync   <= {W{1'b0}};
		end else if (i_ce) begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// >>> src/gps_port_cfg.v
// gps_port_cfg.v: role selection, service request and response time-out for port one
// assumes status_byte comes from same-clock logic; pins pass a synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "gps_consts.vh"

module gps_port_cfg #(
	parameter IFC_CYCLES  = `GPS_IFC_CYCLES,
	parameter SEC_CYCLES  = `GPS_CLK_HZ
) (
	// clock, reset, enable
	input  wire        i_clk,
	input  wire        i_rst_n,
	input  wire        i_ce,
	// rear switch and software commands
	input  wire        i_controller_select_switch,
	input  wire        i_become_controller_command,
	input  wire        i_become_device_command,
	// service request settings and status
	input  wire        i_enable_all,
	input  wire [7:0]  i_status_byte,
	input  wire        i_serial_poll,
	// message settings
	input  wire        i_term_crlf,
	input  wire        i_eom,
	input  wire [`GPS_TMO_SECS_W-1:0] i_timeout_secs,
	input  wire        i_query_rx,
	input  wire        i_response_tx,
	// bus pins, open drain: oe low means pulled low
	output reg         o_srq_out,
	output reg         o_srq_oe_n,
	output reg         o_ifc_out,
	output reg         o_ifc_oe_n,
	// role and status
	output reg         o_system_controller,
	output reg  [7:0]  o_service_request_enable_mask,
	output reg  [7:0]  o_status_byte,
	output reg         o_talker,
	output reg  [7:0]  o_term_char,
	output reg         o_term_valid,
	output reg         o_query_pending,
	output reg         o_query_cancel
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	wire controller_select_switch_sync;

	gps_sync2 #(.W(1)) u_sw_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_async (i_controller_select_switch),
		.o_sync  (controller_select_switch_sync)
	);

	// ------------------------------------------------------------
	// role: power-on strap then software commands
	// ------------------------------------------------------------
	// strap caught after the synchroniser has filled, not at reset
	localparam ROLE_STRAP  = 2'h0;
	localparam ROLE_DEVICE = 2'h1;
	localparam ROLE_CTRL   = 2'h2;
	localparam TERM_IDLE   = 1'h0;
	localparam TERM_CR     = 1'h1;

	reg  [1:0]  role_state_reg;
	reg  [1:0]  role_state_next;
	reg  [1:0]  strap_cnt_reg;
	reg  [1:0]  strap_cnt_next;
	reg  [31:0] ifc_cnt_reg;
	reg  [31:0] ifc_cnt_next;
	reg  [31:0] sec_cnt_reg;
	reg  [`GPS_TMO_SECS_W-1:0] secs_reg;
	reg         term_state_reg;
	reg         term_state_next;
	reg  [7:0]  term_char_next;
	reg         term_valid_next;
	wire [7:0]  mask_next;
	wire        rqs_set;

	assign mask_next = i_enable_all ? `GPS_MASK_ALL_ON : `GPS_MASK_ALL_OFF;
	assign rqs_set   = i_status_byte[`GPS_RQS_BIT];

	always @* begin
		role_state_next = role_state_reg;
		strap_cnt_next  = strap_cnt_reg;
		ifc_cnt_next    = ifc_cnt_reg;
		// interface clear held low for its pulse time
		if (ifc_cnt_reg != 32'h0)
			ifc_cnt_next = ifc_cnt_reg - 32'h1;
		case (role_state_reg)
			ROLE_STRAP: begin
				strap_cnt_next = strap_cnt_reg + 2'h1;
				if (strap_cnt_reg == `GPS_STRAP_TAKE)
					role_state_next = controller_select_switch_sync ? ROLE_CTRL : ROLE_DEVICE;
			end
			ROLE_DEVICE: begin
				// a device command here is refused: no role to give up
				if (i_become_controller_command) begin
					role_state_next = ROLE_CTRL;
					ifc_cnt_next    = IFC_CYCLES;
				end
			end
			ROLE_CTRL: begin
				// controller command wins when both arrive together
				if (i_become_controller_command)
					ifc_cnt_next = IFC_CYCLES;
				else if (i_become_device_command)
					role_state_next = ROLE_DEVICE;
			end
			default: begin
				role_state_next = ROLE_STRAP;
			end
		endcase
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			role_state_reg      <= ROLE_STRAP;
			strap_cnt_reg       <= 2'h0;
			ifc_cnt_reg         <= 32'h0;
			o_system_controller <= 1'b0;
			o_ifc_out           <= 1'b0;
			o_ifc_oe_n          <= 1'b1;
		end else if (i_ce) begin
			role_state_reg      <= role_state_next;
			strap_cnt_reg       <= strap_cnt_next;
			ifc_cnt_reg         <= ifc_cnt_next;
			o_system_controller <= (role_state_next == ROLE_CTRL);
			o_ifc_oe_n          <= (ifc_cnt_reg == 32'h0);
		end
	end

	// ------------------------------------------------------------
	// service request and serial poll
	// ------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_service_request_enable_mask <= `GPS_MASK_ALL_OFF;
			o_status_byte                 <= 8'h00;
			o_srq_out                     <= 1'b0;
			o_srq_oe_n                    <= 1'b1;
			o_talker                      <= 1'b0;
		end else if (i_ce) begin
			o_service_request_enable_mask <= mask_next;
			o_status_byte                 <= i_status_byte;
			// request only with enable on; released as soon as the bit drops
			o_srq_oe_n <= !(rqs_set && i_enable_all);
			// poll makes this device talker for its status message only while requesting with enable on
			o_talker   <= i_serial_poll && rqs_set && i_enable_all;
		end
	end

	// ------------------------------------------------------------
	// terminator: lf, or cr then lf on end of message
	// ------------------------------------------------------------
	always @* begin
		term_state_next = term_state_reg;
		term_char_next  = o_term_char;
		term_valid_next = 1'b0;
		case (term_state_reg)
			TERM_IDLE: begin
				if (i_eom) begin
					term_state_next = i_term_crlf ? TERM_CR : TERM_IDLE;
					term_char_next  = i_term_crlf ? `GPS_CHAR_CR : `GPS_CHAR_LF;
					term_valid_next = 1'b1;
				end
			end
			TERM_CR: begin
				// an end of message here is dropped: the lf is still owed
				term_state_next = TERM_IDLE;
				term_char_next  = `GPS_CHAR_LF;
				term_valid_next = 1'b1;
			end
			default: begin
				term_state_next = TERM_IDLE;
			end
		endcase
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			term_state_reg <= TERM_IDLE;
			o_term_char    <= `GPS_CHAR_LF;
			o_term_valid   <= 1'b0;
		end else if (i_ce) begin
			term_state_reg <= term_state_next;
			o_term_char    <= term_char_next;
			o_term_valid   <= term_valid_next;
		end
	end

	// ------------------------------------------------------------
	// query response time-out
	// ------------------------------------------------------------
	// zero seconds disables the time-out
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_query_pending <= 1'b0;
			o_query_cancel  <= 1'b0;
			sec_cnt_reg     <= 32'h0;
			secs_reg        <= {`GPS_TMO_SECS_W{1'b0}};
		end else if (i_ce) begin
			o_query_cancel <= 1'b0;
			if (i_response_tx) begin
				o_query_pending <= 1'b0;
			end else if (i_query_rx) begin
				o_query_pending <= 1'b1;
				sec_cnt_reg     <= 32'h0;
				secs_reg        <= {`GPS_TMO_SECS_W{1'b0}};
			end else if (o_query_pending && i_timeout_secs != {`GPS_TMO_SECS_W{1'b0}}) begin
				if (sec_cnt_reg == SEC_CYCLES - 1) begin
					sec_cnt_reg <= 32'h0;
					if (secs_reg + 1'b1 == i_timeout_secs) begin
						o_query_pending <= 1'b0;
						o_query_cancel  <= 1'b1;
					end
					secs_reg <= secs_reg + 1'b1;
				end else begin
					sec_cnt_reg <= sec_cnt_reg + 32'h1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// >>> tb/gps_chk_assertions.sv
// gps_chk_assertions.sv: port checks for gps_port_cfg
// assumes one clock domain; bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module gps_chk (
	input wire logic       i_clk, i_rst_n, i_ce, i_enable_all, i_eom, i_term_crlf,
	input wire logic       i_become_controller_command, i_become_device_command,
	input wire logic [7:0] i_status_byte, o_service_request_enable_mask, o_term_char,
	input wire logic       o_srq_oe_n, o_ifc_oe_n, o_system_controller, o_term_valid,
	input wire logic       i_serial_poll, o_talker, o_query_cancel, o_query_pending
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n || !i_ce);
	// cr on the wire: a second end of message is ignored then
	wire cr_busy = o_term_valid && o_term_char == 8'h0d;
	sequence role_taken;
		$rose(o_system_controller) && $past(i_become_controller_command);
	endsequence
	sequence cr_lf;
		cr_busy ##1 o_term_valid && o_term_char == 8'h0a;
	endsequence
	mask_off_a: assert property (
		!i_enable_all |=> o_service_request_enable_mask == 8'h00 && o_srq_oe_n) else $error("not off");
	mask_on_a: assert property (
		i_enable_all |=> o_service_request_enable_mask == 8'hff) else $error("mask not set");
	srq_low_a: assert property (
		i_enable_all && i_status_byte[6] |=> !o_srq_oe_n) else $error("request not driven");
	srq_release_a: assert property (
		!i_status_byte[6] |=> o_srq_oe_n) else $error("request not released");
	ifc_start_a: assert property (
		role_taken |=> !o_ifc_oe_n) else $error("no interface clear");
	device_role_a: assert property (
		o_system_controller && i_become_device_command && !i_become_controller_command
		|=> !o_system_controller) else $error("role kept");
	crlf_term_a: assert property (
		i_eom && i_term_crlf && !cr_busy |=> cr_lf) else $error("bad cr lf");
	lf_term_a: assert property (
		i_eom && !i_term_crlf && !cr_busy |=> o_term_valid && o_term_char == 8'h0a) else $error("bad lf");
	talker_a: assert property (
		i_serial_poll && i_enable_all && i_status_byte[6] |=> o_talker) else $error("no talker");
	cancel_pulse_a: assert property (
		o_query_cancel |-> !o_query_pending ##1 !o_query_cancel) else $error("bad cancel");
endmodule
bind gps_port_cfg gps_chk gps_chk_inst (.i_clk, .i_rst_n, .i_ce, .i_enable_all, .i_eom,
	.i_term_crlf, .i_become_controller_command, .i_become_device_command, .i_status_byte,
	.o_service_request_enable_mask, .o_term_char, .o_srq_oe_n, .o_ifc_oe_n,
	.o_system_controller, .o_term_valid, .i_serial_poll, .o_talker, .o_query_cancel,
	.o_query_pending);
`default_nettype wire

// >>> tb/gps_ctl_model.sv
// gps_ctl_model.sv: bus controller that serial polls on a request
// assumes the talker flag marks the status byte on its way out
`timescale 1ns/1ps
`default_nettype none
module gps_ctl_model #(parameter POLL_DELAY = 3) (
	input  wire logic i_clk,
	input  wire logic i_srq_oe_n,
	input  wire logic i_talker,
	output var  logic o_serial_poll = 1'b0
);
	int cnt = 0;
	always @(posedge i_clk) begin
		if (!o_serial_poll && !i_srq_oe_n) begin
			cnt <= cnt + 1;
			if (cnt == POLL_DELAY) o_serial_poll <= 1'b1;
		end else if (i_talker) begin
			o_serial_poll <= 1'b0;
			cnt <= 0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/gpib_port_config_srq_bench.sv
// gpib_port_config_srq_bench.sv: directed bench for gps_port_cfg
// assumes short interface clear and second counts
`timescale 1ns/1ps
`default_nettype none
module gpib_port_config_srq_bench;
	logic       clk = 0, rst_n = 0, sw = 0, bc = 0, bd = 0, en = 0;
	logic       eom = 0, crlf = 0, qry = 0, rsp = 0;
	logic [7:0] stb = 8'h00, tmo = 8'h01;
	wire        soe, ifc, role, tlk, tv, qp, qc, poll, so, io;
	wire  [7:0] mask, ch, sb;
	int         mismatches = 0, checks = 0, n;
	initial forever #10 clk = ~clk;
	gps_port_cfg #(.IFC_CYCLES(4), .SEC_CYCLES(10)) gps_port_cfg_inst (.i_clk(clk),
		.i_rst_n(rst_n), .i_ce(1'b1), .i_controller_select_switch(sw),
		.i_become_controller_command(bc), .i_become_device_command(bd), .i_enable_all(en),
		.i_status_byte(stb), .i_serial_poll(poll), .i_term_crlf(crlf), .i_eom(eom),
		.i_timeout_secs(tmo), .i_query_rx(qry), .i_response_tx(rsp), .o_srq_out(so),
		.o_srq_oe_n(soe), .o_ifc_out(io), .o_ifc_oe_n(ifc), .o_system_controller(role),
		.o_service_request_enable_mask(mask), .o_status_byte(sb), .o_talker(tlk),
		.o_term_char(ch), .o_term_valid(tv), .o_query_pending(qp), .o_query_cancel(qc));
	gps_ctl_model gps_ctl_model_inst (.i_clk(clk), .i_srq_oe_n(soe), .i_talker(tlk),
		.o_serial_poll(poll));
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic boot(input logic s);
		rst_n = 0;
		sw = s;
		cyc(10);
		rst_n = 1;
		cyc(5);
		chk("power-on role", 8'(s), 8'(role));
	endtask
	// hang guard: every wait below is bounded too
	initial begin
		cyc(3000);
		mismatches++;
		final_report;
	end
	initial begin
		boot(1'b0);
		boot(1'b1);
		bd = 1;
		cyc(1);
		chk("device command", 8'h00, 8'(role));
		bc = 1;
		cyc(1);
		bc = 0;
		bd = 0;
		chk("controller command", 8'h01, 8'(role));
		cyc(1);
		for (n = 0; n < 20 && ifc === 1'b0; n++) cyc(1);
		chk("clear length", 8'h04, 8'(n));
		$display("role test done");
		en = 1;
		stb = 8'h40;
		cyc(1);
		chk("request line", 8'h00, 8'(soe));
		chk("mask on", 8'hff, mask);
		chk("status copy", 8'h40, sb);
		chk("request level", 8'h00, 8'(so));
		chk("clear level", 8'h00, 8'(io));
		for (n = 0; n < 20 && tlk !== 1'b1; n++) cyc(1);
		chk("talker", 8'h01, 8'(tlk));
		stb = 8'h00;
		cyc(1);
		chk("request released", 8'h01, 8'(soe));
		chk("status cleared", 8'h00, sb);
		en = 0;
		stb = 8'h40;
		cyc(1);
		chk("request blocked", 8'h01, 8'(soe));
		chk("mask off", 8'h00, mask);
		$display("request test done");
		for (int c = 0; c < 2; c++) begin
			crlf = c[0];
			eom = 1;
			cyc(1);
			eom = 0;
			chk("first char", c ? 8'h0d : 8'h0a, ch);
			chk("char valid", 8'h01, 8'(tv));
			cyc(c);
			chk("line feed", 8'h0a, ch);
			chk("lf valid", 8'h01, 8'(tv));
			cyc(1);
			chk("valid drop", 8'h00, 8'(tv));
		end
		$display("terminator test done");
		for (int s = 1; s < 3; s++) begin
			tmo = 8'(s);
			qry = 1;
			cyc(1);
			qry = 0;
			chk("pending", 8'h01, 8'(qp));
			for (n = 0; n < 40 && qc !== 1'b1; n++) cyc(1);
			chk("cancel", 8'h01, 8'(qc));
			chk("time-out length", 8'(s * 10), 8'(n));
			chk("pending dropped", 8'h00, 8'(qp));
			cyc(1);
			chk("cancel pulse", 8'h00, 8'(qc));
		end
		qry = 1;
		cyc(1);
		qry = 0;
		cyc(3);
		rsp = 1;
		cyc(1);
		rsp = 0;
		chk("response clears", 8'h00, 8'(qp));
		for (n = 0; n < 30 && qc !== 1'b1; n++) cyc(1);
		chk("no cancel", 8'h00, 8'(qc));
		$display("time-out test done");
		final_report;
	end
endmodule
`default_nettype wire
